// *** bench/bgc_ctrl_properties.sv ***
// Port-level assertions for the general control register block
module bgc_ctrl_properties (
	input wire aclk,
	input wire aresetn,
	input wire in_d3,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid,
	input wire prefetch_off,
	input wire burst_single_dword,
	input wire [2:0] cap_standby_latency,
	input wire [2:0] cap_sleep_latency,
	input wire [11:0] aer_next_offset,
	input wire sec_clk_run,
	input wire [7:0] min_power_value
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========================================
	// Write steps
	sequence s_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wctl;
		s_both ##0 s_axi_awaddr == 4'h0;
	endsequence
	// ==========================================
	// Properties
	property p_stby;
		s_wctl ##0 s_axi_wstrb[2] |=>
			cap_standby_latency == $past(s_axi_wdata[18:16]);
	endproperty
	a_stby: assert property (p_stby) else $error("standby mirror");
	property p_slp;
		s_wctl ##0 s_axi_wstrb[1] |=>
			cap_sleep_latency == $past(s_axi_wdata[15:13]);
	endproperty
	a_slp: assert property (p_slp) else $error("sleep mirror");
	property p_vc;
		s_wctl ##0 s_axi_wstrb[1] |=>
			aer_next_offset ==
			($past(s_axi_wdata[12]) ? 12'h150 : 12'h000);
	endproperty
	a_vc: assert property (p_vc) else $error("next offset");
	property p_mpv;
		s_wctl ##0 s_axi_wstrb[0] |=>
			min_power_value == $past(s_axi_wdata[7:0]);
	endproperty
	a_mpv: assert property (p_mpv) else $error("min power value");
	property p_pf;
		s_wctl ##0 s_axi_wstrb[2] |=>
			prefetch_off == $past(s_axi_wdata[19]) &&
			burst_single_dword == prefetch_off;
	endproperty
	a_pf: assert property (p_pf) else $error("prefetch");
	property p_wr;
		s_both ##0 s_axi_awaddr[1:0] == 2'h0 |=> s_axi_bvalid &&
			s_axi_bresp == ($past(s_axi_awaddr) > 4'h8 ? 2'h2 : 2'h0);
	endproperty
	a_wr: assert property (p_wr) else $error("write answer");
	property p_rd;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd: assert property (p_rd) else $error("read answer");
	// Two-flop sync chain, combinational output: a settled low D3 always lets clocks run
	property p_clk;
		!in_d3 [*4] |-> sec_clk_run;
	endproperty
	a_clk: assert property (p_clk) else $error("clock stop");
	property p_dflt;
		$rose(aresetn) |-> cap_standby_latency == 3'h6 &&
			cap_sleep_latency == 3'h6 && !prefetch_off &&
			min_power_value == 8'h00;
	endproperty
	a_dflt: assert property (p_dflt) else $error("reset defaults");
endmodule
bind bgc_ctrl bgc_ctrl_properties i_props (.*);

// *** bench/tb.sv ***
// Self-checking bench for the general control register block
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = 1'h0, aresetn = 1'h0, aux_resetn = 1'h0, in_d3 = 1'h0;
	logic [2:0] arst_n = 3'h7;
	wire link_reset_n = arst_n[0];
	wire global_reset_in_n = arst_n[1];
	wire por_n = arst_n[2];
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
	wire prefetch_off, burst_single_dword, sec_clk_run, beacon_wake_en;
	wire [1:0] s_axi_bresp, s_axi_rresp, min_power_scale;
	wire [31:0] s_axi_rdata;
	wire [2:0] cap_standby_latency, cap_sleep_latency;
	wire [11:0] aer_next_offset;
	wire [7:0] min_power_value;
	int num_errors = 0, n_compared = 0, cyc = 0, i;
	logic [31:0] w, d;
	logic [11:0] nx;
	logic [1:0] r;
	// Every latency code appears once in each field
	logic [31:0] rows [8] = '{32'h8F4FF, 32'h1C901, 32'h2B280, 32'hB8355,
		32'h474AA, 32'hD490F, 32'h632F0, 32'h70000};
	bgc_ctrl i_dut (.*);
	initial begin
		forever #20 aclk = ~aclk;
	end
	// ==========================================
	// Tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// Leading edge keeps a release and the next request apart
	task wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task end_sim;
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			end_sim;
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'h1;
		aux_resetn <= 1'h1;
		rd(4'h0, d, r);
		chk(d, 32'h6C000);
		chk(aer_next_offset, 12'h000);
		for (i = 0; i < 8; i++) begin
			w = rows[i];
			nx = w[12] ? 12'h150 : 12'h000;
			wr(4'h0, w, r);
			chk(r, 2'h0);
			chk(prefetch_off, w[19]);
			chk(burst_single_dword, w[19]);
			chk(cap_standby_latency, w[18:16]);
			chk(cap_sleep_latency, w[15:13]);
			chk(aer_next_offset, nx);
			chk(beacon_wake_en, w[10]);
			chk(min_power_scale, w[9:8]);
			chk(min_power_value, w[7:0]);
			rd(4'h0, d, r);
			chk(d, w);
			rd(4'h4, d, r);
			chk(d, {nx, 8'h00, w[15:13], w[18:16], 6'h00});
		end
		wr(4'h0, 32'h00800, r);
		in_d3 <= 1'h1;
		repeat (5) @(posedge aclk);
		chk(sec_clk_run, 1'h0);
		rd(4'h8, d, r);
		chk(d, 32'h3);
		wr(4'h0, 32'h00000, r);
		chk(sec_clk_run, 1'h1);
		in_d3 <= 1'h0;
		wr(4'h0, 32'h8FCFF, r);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		rd(4'h0, d, r);
		chk(d, 32'h6CC00);
		for (i = 0; i < 3; i++) begin
			wr(4'h0, 32'h8F4FF, r);
			arst_n[i] <= 1'h0;
			repeat (4) @(posedge aclk);
			arst_n[i] <= 1'h1;
			repeat (4) @(posedge aclk);
			rd(4'h0, d, r);
			chk(d, 32'h6C400);
		end
		aux_resetn <= 1'h0;
		@(posedge aclk);
		aux_resetn <= 1'h1;
		@(posedge aclk);
		chk(beacon_wake_en, 1'h0);
		s_axi_wstrb <= 4'h5;
		wr(4'h0, 32'h8FFAA, r);
		s_axi_wstrb <= 4'hF;
		wr(4'h4, 32'hFFFFF, r);
		chk(r, 2'h0);
		rd(4'h0, d, r);
		chk(d, 32'h8C0AA);
		wr(4'hC, 32'hFFFFF, r);
		chk(r, 2'h2);
		rd(4'hC, d, r);
		chk(d, 32'h0);
		chk(r, 2'h2);
		end_sim;
	end
endmodule

// *** rtl/bgc_ctrl.v ***
// General control register, low twenty bits, behind an AXI4-Lite slave
// ==========================================
// Summary of operation
// - Prefetch bit 0 fetches to cache line end; 1 fetches one dword.
// - Standby exit latency field mirrors into capability bits 8:6.
// - Standby latency codes double from 64 ns; reset code is 110.
// - Sleep exit latency field mirrors into capability bits 11:9.
// - Sleep latency codes double from 1 us; reset code is 110.
// - Virtual channel bit picks next offset 150h, else 000h.
// - Clock-stop bit set stops secondary clocks while in D3.
// - Beacon bit 0 wakes by wake signal only; 1 adds beacon.
// - Two-bit minimum power scale, 00 is 1.0x by default.
// - Eight-bit minimum power value, default 00h, reprogrammable.
// - Non-sticky fields reset on link, global or power-on reset.
// - Clock-stop and beacon bits survive resets while on aux power.
`include "bgc_map.vh"
module bgc_ctrl (
	aclk,
	aresetn,
	link_reset_n,
	global_reset_in_n,
	por_n,
	aux_resetn,
	in_d3,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	prefetch_off,
	burst_single_dword,
	cap_standby_latency,
	cap_sleep_latency,
	aer_next_offset,
	sec_clk_run,
	beacon_wake_en,
	min_power_scale,
	min_power_value
);
	input wire aclk;
	input wire aresetn;
	input wire link_reset_n;
	input wire global_reset_in_n;
	input wire por_n;
	input wire aux_resetn;
	input wire in_d3;
	input wire [3:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output wire s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output wire s_axi_wready;
	output reg [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [3:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output wire s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;
	output wire prefetch_off;
	output wire burst_single_dword;
	output wire [2:0] cap_standby_latency;
	output wire [2:0] cap_sleep_latency;
	output wire [11:0] aer_next_offset;
	output wire sec_clk_run;
	output wire beacon_wake_en;
	output wire [1:0] min_power_scale;
	output wire [7:0] min_power_value;

	// ==========================================
	// Synchronisers for the asynchronous reset sources and D3 level
	reg [1:0] lrst_s_q;
	reg [1:0] global_reset_in_s_q;
	reg [1:0] por_s_q;
	reg [1:0] d3_s_q;
	always @(posedge aclk) begin
		lrst_s_q <= {lrst_s_q[0], link_reset_n};
		global_reset_in_s_q <= {global_reset_in_s_q[0], global_reset_in_n};
		por_s_q <= {por_s_q[0], por_n};
		d3_s_q <= {d3_s_q[0], in_d3};
	end
	// Any of the three sources, or the bus reset, clears the plain fields
	wire field_rst = !aresetn || !lrst_s_q[1] || !global_reset_in_s_q[1] ||
		!por_s_q[1];

	// ==========================================
	// Write channel: address and data taken in either order
	reg aw_hold_q;
	reg [3:0] aw_addr_q;
	reg w_hold_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
	assign s_axi_wready = !w_hold_q && !s_axi_bvalid;
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire have_aw = aw_hold_q || aw_fire;
	wire have_w = w_hold_q || w_fire;
	wire [3:0] wr_addr = aw_hold_q ? aw_addr_q : s_axi_awaddr;
	wire [31:0] wr_data = w_hold_q ? w_data_q : s_axi_wdata;
	wire [3:0] wr_strb = w_hold_q ? w_strb_q : s_axi_wstrb;
	wire wr_go = have_aw && have_w && !s_axi_bvalid;

	function is_mapped;
		input [3:0] a;
		begin
			is_mapped = (a == `BGC_ADDR_CTRL) || (a == `BGC_ADDR_CAPS) ||
				(a == `BGC_ADDR_STAT);
		end
	endfunction

	wire ctrl_wr = wr_go && (wr_addr == `BGC_ADDR_CTRL);

	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h0;
			w_strb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `BGC_RESP_OKAY;
		end else begin
			if (aw_fire && !wr_go) begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (w_fire && !wr_go) begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= is_mapped(wr_addr) ? `BGC_RESP_OKAY :
					`BGC_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Plain control fields
	reg prefetch_q;
	reg [2:0] standby_q;
	reg [2:0] sleep_q;
	reg vcs_q;
	reg [1:0] scale_q;
	reg [7:0] minpwr_q;
	always @(posedge aclk) begin
		if (field_rst) begin
			prefetch_q <= 1'b0;
			standby_q <= `BGC_STANDBY_RST;
			sleep_q <= `BGC_SLEEP_RST;
			vcs_q <= 1'b0;
			scale_q <= `BGC_SCALE_RST;
			minpwr_q <= `BGC_MINPWR_RST;
		end else if (ctrl_wr) begin
			if (wr_strb[0])
				minpwr_q <= wr_data[`BGC_MINPWR_HI:`BGC_MINPWR_LO];
			if (wr_strb[1]) begin
				scale_q <= wr_data[`BGC_SCALE_HI:`BGC_SCALE_LO];
				vcs_q <= wr_data[`BGC_VCS_BIT];
				sleep_q[0] <= wr_data[`BGC_SLEEP_LO];
				sleep_q[2:1] <= wr_data[`BGC_SLEEP_HI:`BGC_SLEEP_LO + 1];
			end
			if (wr_strb[2]) begin
				standby_q <= wr_data[`BGC_STANDBY_HI:`BGC_STANDBY_LO];
				prefetch_q <= wr_data[`BGC_PREFETCH_BIT];
			end
		end
	end

	// ==========================================
	// Sticky bits, cleared only by the aux-power reset
	wire clkstop_q;
	wire beacon_q;
	bgc_sticky u_sticky (
		.aclk(aclk),
		.aux_resetn(aux_resetn),
		.wr_en(ctrl_wr && wr_strb[1]),
		.wr_clkstop(wr_data[`BGC_CLKSTOP_BIT]),
		.wr_beacon(wr_data[`BGC_BEACON_BIT]),
		.clkstop_q(clkstop_q),
		.beacon_q(beacon_q)
	);

	// ==========================================
	// Outputs: mirrors follow the fields combinationally
	assign prefetch_off = prefetch_q;
	assign burst_single_dword = prefetch_q;
	assign cap_standby_latency = standby_q;
	assign cap_sleep_latency = sleep_q;
	assign aer_next_offset = vcs_q ? `BGC_NEXT_VC : `BGC_NEXT_NONE;
	// Clocks stop only in D3 with the enable set
	assign sec_clk_run = !(clkstop_q && d3_s_q[1]);
	assign beacon_wake_en = beacon_q;
	assign min_power_scale = scale_q;
	assign min_power_value = minpwr_q;

	wire [31:0] ctrl_word = {12'h000, prefetch_q, standby_q, sleep_q, vcs_q,
		clkstop_q, beacon_q, scale_q, minpwr_q};
	wire [31:0] caps_word = {aer_next_offset, 20'h00000} |
		({29'h0, standby_q} << `BGC_CAP_STANDBY_LO) |
		({29'h0, sleep_q} << `BGC_CAP_SLEEP_LO);
	wire [31:0] stat_word = {30'h0, !sec_clk_run, d3_s_q[1]};

	// ==========================================
	// Read channel, one-cycle answer
	assign s_axi_arready = !s_axi_rvalid;
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= `BGC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= is_mapped(s_axi_araddr) ? `BGC_RESP_OKAY :
				`BGC_RESP_SLVERR;
			case (s_axi_araddr)
				`BGC_ADDR_CTRL: s_axi_rdata <= ctrl_word;
				`BGC_ADDR_CAPS: s_axi_rdata <= caps_word;
				`BGC_ADDR_STAT: s_axi_rdata <= stat_word;
				default: s_axi_rdata <= 32'h0;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule

// *** rtl/bgc_sticky.v ***
// Sticky control bits kept alive on auxiliary power
module bgc_sticky (
	aclk,
	aux_resetn,
	wr_en,
	wr_clkstop,
	wr_beacon,
	clkstop_q,
	beacon_q
);
	input wire aclk;
	input wire aux_resetn;
	input wire wr_en;
	input wire wr_clkstop;
	input wire wr_beacon;
	output reg clkstop_q;
	output reg beacon_q;

	// ==========================================
	// Only the aux-power reset clears these
	always @(posedge aclk) begin
		if (!aux_resetn) begin
			clkstop_q <= 1'b0;
			beacon_q <= 1'b0;
		end else if (wr_en) begin
			clkstop_q <= wr_clkstop;
			beacon_q <= wr_beacon;
		end
	end
endmodule

// *** shared/bgc_map.vh ***
// Register map, field positions and reset values of the general control block
`ifndef BGC_MAP_VH
`define BGC_MAP_VH
// ==========================================
// Byte addresses
`define BGC_ADDR_CTRL 4'h0
`define BGC_ADDR_CAPS 4'h4
`define BGC_ADDR_STAT 4'h8
// ==========================================
// Field positions within the control word
`define BGC_PREFETCH_BIT 19
`define BGC_STANDBY_HI 18
`define BGC_STANDBY_LO 16
`define BGC_SLEEP_HI 15
`define BGC_SLEEP_LO 13
`define BGC_VCS_BIT 12
`define BGC_CLKSTOP_BIT 11
`define BGC_BEACON_BIT 10
`define BGC_SCALE_HI 9
`define BGC_SCALE_LO 8
`define BGC_MINPWR_HI 7
`define BGC_MINPWR_LO 0
// ==========================================
// Reset values
`define BGC_STANDBY_RST 3'h6
`define BGC_SLEEP_RST 3'h6
`define BGC_SCALE_RST 2'h0
`define BGC_MINPWR_RST 8'h00
// ==========================================
// Next-capability offsets and device-capability field positions
`define BGC_NEXT_VC 12'h150
`define BGC_NEXT_NONE 12'h000
`define BGC_CAP_STANDBY_LO 6
`define BGC_CAP_SLEEP_LO 9
// AXI responses
`define BGC_RESP_OKAY 2'h0
`define BGC_RESP_SLVERR 2'h2
`endif
